// ### dv/rls_host_model.sv
// Host model issuing one-cycle counter and configuration writes
`timescale 1ns/1ps
module rls_host_model (
  input wire clk_i,
  output reg [7:0] wr_en_o = 8'h00,
  output reg [31:0] wr_data_o = 32'h0
);
  task wr(input [7:0] en, input [31:0] d);
  begin
    @(posedge clk_i);
    wr_en_o <= en;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o <= 8'h00;
    wr_data_o <= ~d; // Stale data must not pass for valid
  end
  endtask
endmodule // rls_host_model

// ### dv/rls_top_assertions.sv
// Port checker for the radio link statistics block
`timescale 1ns/1ps
module rls_top_checker #(parameter [23:0] POLL_CYCLES = 24'h000008) (
  input wire SYS_CLK_I, RSTN_I, RX_FRAME_I, RX_IS_ACK_I, ACK_TIMEOUT_I,
  input wire [7:0] TX_BYTES_I, WR_EN_I, RSSI_LAST_HOP_O,
  input wire [31:0] WR_DATA_I, TX_BYTE_COUNT_O,
  input wire [15:0] GOOD_RX_FRAMES_O, ACK_TIMEOUT_COUNT_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  property p_gd; RX_FRAME_I && !RX_IS_ACK_I && !WR_EN_I[1] && GOOD_RX_FRAMES_O != 16'hFFFF
    |=> GOOD_RX_FRAMES_O == $past(GOOD_RX_FRAMES_O) + 16'h0001; endproperty
  a_gd: assert property (p_gd) else $error("frame missed");
  property p_ack; RX_FRAME_I && RX_IS_ACK_I && !WR_EN_I[1] |=> $stable(GOOD_RX_FRAMES_O); endproperty
  a_ack: assert property (p_ack) else $error("ack counted");
  property p_gwr; WR_EN_I[1] |=> GOOD_RX_FRAMES_O == $past(WR_DATA_I[15:0]); endproperty
  a_gwr: assert property (p_gwr) else $error("load lost");
  property p_ea; ACK_TIMEOUT_I && !WR_EN_I[3] && ACK_TIMEOUT_COUNT_O != 16'hFFFF
    |=> ACK_TIMEOUT_COUNT_O == $past(ACK_TIMEOUT_COUNT_O) + 16'h0001; endproperty
  a_ea: assert property (p_ea) else $error("timeout missed");
  property p_sat; ACK_TIMEOUT_COUNT_O == 16'hFFFF && !WR_EN_I[3] |=> ACK_TIMEOUT_COUNT_O == 16'hFFFF; endproperty
  a_sat: assert property (p_sat) else $error("wrapped");
  property p_bc; !WR_EN_I[2] |=> TX_BYTE_COUNT_O == $past(TX_BYTE_COUNT_O) + $past(TX_BYTES_I); endproperty
  a_bc: assert property (p_bc) else $error("bytes wrong");
  property p_bwr; WR_EN_I[2] |=> TX_BYTE_COUNT_O == $past(WR_DATA_I); endproperty
  a_bwr: assert property (p_bwr) else $error("byte load lost");
  property p_rst; $rose(RSTN_I) |-> RSSI_LAST_HOP_O == 8'h00 && GOOD_RX_FRAMES_O == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  c_sat: cover property (ACK_TIMEOUT_I && ACK_TIMEOUT_COUNT_O == 16'hFFFF);
  c_ack: cover property (RX_FRAME_I && RX_IS_ACK_I);
  c_wr: cover property (WR_EN_I[1] && RX_FRAME_I);
endmodule // rls_top_checker
bind rls_top rls_top_checker #(.POLL_CYCLES(POLL_CYCLES)) i_chk (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
  .RX_FRAME_I(RX_FRAME_I), .RX_IS_ACK_I(RX_IS_ACK_I), .ACK_TIMEOUT_I(ACK_TIMEOUT_I), .TX_BYTES_I(TX_BYTES_I),
  .WR_EN_I(WR_EN_I), .RSSI_LAST_HOP_O(RSSI_LAST_HOP_O), .WR_DATA_I(WR_DATA_I), .TX_BYTE_COUNT_O(TX_BYTE_COUNT_O),
  .GOOD_RX_FRAMES_O(GOOD_RX_FRAMES_O), .ACK_TIMEOUT_COUNT_O(ACK_TIMEOUT_COUNT_O));

// ### dv/test_rls_top.sv
// Self-checking bench for the radio link statistics block
`timescale 1ns/1ps
module test_rls_top;
  reg clk = 1'b0, rstn = 1'b0, rx = 1'b0, ak = 1'b0, us = 1'b0, ato = 1'b0, cca = 1'b0, rxb = 1'b0, sf = 1'b0;
  reg api = 1'b0, preq = 1'b0;
  reg [2:0] rate = 3'h1;
  wire routes, rep, hold, poll, rel;
  integer j, n;
  reg [7:0] rssi = 8'h00, txb = 8'h00, ftf = 8'h00, ccl = 8'h00;
  reg [5:0] frad = 6'h00;
  reg [3:0] rl = 4'hA;
  wire [7:0] we, rh, opt, etf;
  wire [31:0] wd, bc;
  wire [15:0] ua, gd, ea, ec, tf;
  wire [5:0] bh, nh, ebh;
  wire [2:0] role;
  integer err_count = 0, checks = 0, i;
  reg [62:0] rows [0:4];
  always #50 clk = ~clk;
  rls_host_model i_host (.clk_i(clk), .wr_en_o(we), .wr_data_o(wd));
  rls_top #(.POLL_CYCLES(24'h000008)) i_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .RX_FRAME_I(rx), .RX_IS_ACK_I(ak),
    .RX_RSSI_I(rssi), .UNICAST_SENT_I(us), .TX_BYTES_I(txb), .ACK_TIMEOUT_I(ato), .CCA_BLOCK_I(cca),
    .RX_BUSY_BLOCK_I(rxb), .SEND_FAIL_I(sf), .API_MODE_I(api), .FRAME_VALID_I(api), .FRAME_TX_FLAGS_I(ftf),
    .FRAME_BCAST_RADIUS_I(frad), .POLL_REQ_I(preq), .WR_EN_I(we), .WR_DATA_I(wd), .MAC_RETRY_LIMIT_I(rl),
    .CLEAR_CHAN_LEVEL_I(ccl), .RF_DATA_RATE_I(rate), .RSSI_LAST_HOP_O(rh), .UNICAST_TRY_COUNT_O(ua),
    .GOOD_RX_FRAMES_O(gd), .TX_BYTE_COUNT_O(bc), .ACK_TIMEOUT_COUNT_O(ea), .CCA_BLOCKED_COUNT_O(ec),
    .SEND_FAIL_COUNT_O(tf), .ROUTE_ROLE_O(role), .TX_OPTION_BITS_O(opt), .BCAST_HOP_LIMIT_O(bh),
    .NET_HOP_MAX_O(nh), .EFF_TX_FLAGS_O(etf), .EFF_BCAST_HOPS_O(ebh), .ROUTES_O(routes), .REPEAT_BCAST_O(rep),
    .HOLD_P2MP_O(hold), .POLL_PULSE_O(poll), .RELEASE_HELD_O(rel));
  task chk(input [31:0] s, input [31:0] e);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Whole run needs about eighty cycles; limit allows over twelve times that
  initial
  begin
    #100000;
    err_count = err_count + 1;
    test_done;
  end
  initial
  begin
    rows[0] = {8'h40, 32'h4, 3'h4, 8'hC0, 6'h00, 6'h07};
    rows[1] = {8'h40, 32'h7, 3'h4, 8'hC0, 6'h00, 6'h07};
    rows[2] = {8'h80, 32'hF10A21, 3'h4, 8'hC1, 6'h00, 6'h0A};
    rows[3] = {8'h80, 32'h412010, 3'h4, 8'h41, 6'h10, 6'h20};
    rows[4] = {8'h80, 32'hC00520, 3'h4, 8'hC0, 6'h20, 6'h05};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1 chk({rh, opt, nh}, 22'h003007);
    for (i = 0; i < 5; i = i + 1)
    begin
      i_host.wr(rows[i][62:55], rows[i][54:23]);
      #1 chk({role, opt, bh, nh}, rows[i][22:0]);
    end
    @(posedge clk);
    api <= 1'b1; frad <= 6'h09; ftf <= 8'h41;
    #1 chk({ebh, etf}, 14'h05C0);
    @(posedge clk) #1 chk({ebh, etf}, 14'h0941);
    $display("configuration tests done");
    @(posedge clk);
    api <= 1'b0; rx <= 1'b1; rssi <= 8'h2A;
    @(posedge clk);
    ak <= 1'b1; rssi <= 8'h60;
    @(posedge clk);
    ak <= 1'b0; ato <= 1'b1; sf <= 1'b1;
    #1 chk({gd, rh}, 24'h00012A);
    i_host.wr(8'h2E, 32'hFFFFFFFE);
    #1 chk({gd, ea}, 32'hFFFEFFFE);
    chk(bc, 32'hFFFFFFFE);
    repeat (2) @(posedge clk);
    #1 chk({gd, ea}, 32'hFFFFFFFF);
    chk(tf, 16'hFFFF);
    @(posedge clk);
    rx <= 1'b0; ato <= 1'b0; sf <= 1'b0; us <= 1'b1; cca <= 1'b1; rl <= 4'h0; txb <= 8'h10;
    @(posedge clk);
    rl <= 4'h3; cca <= 1'b0; rxb <= 1'b1;
    @(posedge clk);
    ccl <= 8'h40; cca <= 1'b1; rxb <= 1'b0;
    @(posedge clk) #1 chk({ua, ec}, 32'h00020002);
    chk(bc, 32'h0000002E);
    $display("counter tests done");
    chk({routes, rep, hold}, 3'h6);
    n = 0;
    for (j = 0; j < 24; j = j + 1)
    begin
      @(posedge clk) #1 n = n + poll;
    end
    chk(n, 3);
    @(posedge clk);
    api <= 1'b1; ftf <= 8'hCF;
    @(posedge clk) #1 chk(etf, 8'hCF);
    @(posedge clk);
    ftf <= 8'h8C;
    @(posedge clk) #1 chk(etf, 8'h80);
    @(posedge clk);
    ftf <= 8'hCF; rate <= 3'h0;
    @(posedge clk) #1 chk({etf, rep}, 9'h006);
    @(posedge clk);
    api <= 1'b0; rate <= 3'h1;
    i_host.wr(8'h40, 32'h1);
    @(posedge clk);
    preq <= 1'b1;
    @(posedge clk) #1 chk({hold, rel, routes}, 3'h7);
    @(posedge clk);
    preq <= 1'b0;
    @(posedge clk) #1 chk(rel, 1'b0);
    $display("role and option tests done");
    @(posedge clk);
    rstn <= 1'b0;
    #1 chk({gd, bc[15:0]}, 32'h0);
    test_done;
  end
endmodule // test_rls_top

// ### include/rls_consts.vh
// Reset values and field positions for the radio link statistics block
`ifndef RLS_CONSTS_VH
`define RLS_CONSTS_VH
`define RLS_CNT16_MAX 16'hFFFF
`define RLS_CNT32_MAX 32'hFFFFFFFF
`define RLS_RSSI_RST 8'h00
`define RLS_CNT16_RST 16'h0000
`define RLS_CNT32_RST 32'h00000000
`define RLS_ROLE_RST 3'h0
`define RLS_ROLE_MAX 3'h6
`define RLS_TXOPT_RST 8'hC0
`define RLS_BHOP_RST 6'h00
`define RLS_BHOP_MAX 6'h20
`define RLS_NHOP_RST 6'h07
`define RLS_NHOP_MIN 6'h01
`define RLS_NHOP_MAX 6'h20
`define RLS_RETRY_RST 4'hA
`define RLS_TXOPT_DM_HI 7
`define RLS_TXOPT_DM_LO 6
`define RLS_TXOPT_RSV_HI 5
`define RLS_TXOPT_RSV_LO 4
`define RLS_TXOPT_TRACE 3
`define RLS_TXOPT_NACK 2
`define RLS_TXOPT_NORD 1
`define RLS_TXOPT_NOACK 0
`define RLS_DM_MESH 2'h3
`define RLS_DM_DBCAST 2'h2
`define RLS_DM_P2MP 2'h1
`define RLS_POLL_CYCLES 24'h0F4240
`endif

// ### logic/rls_top.v
// Radio link statistics counters and link configuration bits
`timescale 1ns/1ps
`include "rls_consts.vh"
// What this block does
// - Hold magnitude of last received packet signal strength, last hop only
// - Signal strength reads zero after reset until a packet arrives
// - Count unicasts requesting acknowledgement, only while retry limit above zero
// - Count good frames with valid MAC header, excluding received acknowledgements
// - Good-frame, ack-timeout and send-failure counters saturate at 0xFFFF
// - Host write with value loads the addressed counter
// - Transmitted byte counter is 32 bits, adds every byte sent
// - Ack-timeout counter increments on every MAC acknowledgement timeout
// - Channel-block counter counts CCA and receive blocks; only receive blocks when threshold zero
// - Channel-block counter saturates and accepts host writes anytime
// - Send-failure counter increments when retries are exhausted without acknowledgement
// - All diagnostic values volatile, zero after power-up
// - Routing role 0 to 6, default 0; roles 0, 1, 4 route
// - Routing nodes repeat broadcasts; coordinator holds unicasts until requested
// - Poller roles send poll requests at regular intervals
// - Option bits 7:6 select delivery; bits 5:4 reserved, written zero
// - Bit 3 trace route, 2 NACK, 1 no route discovery, 0 no ack
// - Stored options default 0xC0; frame options override per transmission
// - Data rate zero disables mesh delivery and repeater operation
// - Broadcast hop limit 0 to 0x20, clamped to network hop limit
// - In API mode broadcast radius comes from the frame
// - Nonzero retry limit requests ack; limit ranges 0 to 15
module rls_top #(
  parameter [23:0] POLL_CYCLES = `RLS_POLL_CYCLES
) (
  input wire SYS_CLK_I,
  input wire RSTN_I,
  input wire RX_FRAME_I,
  input wire RX_IS_ACK_I,
  input wire [7:0] RX_RSSI_I,
  input wire UNICAST_SENT_I,
  input wire [7:0] TX_BYTES_I,
  input wire ACK_TIMEOUT_I,
  input wire CCA_BLOCK_I,
  input wire RX_BUSY_BLOCK_I,
  input wire SEND_FAIL_I,
  input wire API_MODE_I,
  input wire FRAME_VALID_I,
  input wire [7:0] FRAME_TX_FLAGS_I,
  input wire [5:0] FRAME_BCAST_RADIUS_I,
  input wire POLL_REQ_I,
  input wire [7:0] WR_EN_I,
  input wire [31:0] WR_DATA_I,
  input wire [3:0] MAC_RETRY_LIMIT_I,
  input wire [7:0] CLEAR_CHAN_LEVEL_I,
  input wire [2:0] RF_DATA_RATE_I,
  output reg [7:0] RSSI_LAST_HOP_O,
  output reg [15:0] UNICAST_TRY_COUNT_O,
  output reg [15:0] GOOD_RX_FRAMES_O,
  output reg [31:0] TX_BYTE_COUNT_O,
  output reg [15:0] ACK_TIMEOUT_COUNT_O,
  output reg [15:0] CCA_BLOCKED_COUNT_O,
  output reg [15:0] SEND_FAIL_COUNT_O,
  output reg [2:0] ROUTE_ROLE_O,
  output reg [7:0] TX_OPTION_BITS_O,
  output reg [5:0] BCAST_HOP_LIMIT_O,
  output reg [5:0] NET_HOP_MAX_O,
  output reg [7:0] EFF_TX_FLAGS_O,
  output reg [5:0] EFF_BCAST_HOPS_O,
  output reg ROUTES_O,
  output reg REPEAT_BCAST_O,
  output reg HOLD_P2MP_O,
  output reg POLL_PULSE_O,
  output reg RELEASE_HELD_O
);

  // Write enables: 0 unicast,1 good,2 bytes,3 ack timeout,4 cca,5 fail,6 role,7 hop/option config
  wire retry_on = (MAC_RETRY_LIMIT_I != 4'h0);
  wire cca_ev = RX_BUSY_BLOCK_I | (CCA_BLOCK_I & (CLEAR_CHAN_LEVEL_I != 8'h00));
  wire [32:0] byte_sum = {1'b0, TX_BYTE_COUNT_O} + {25'h0000000, TX_BYTES_I};
  wire [2:0] role_nxt = (WR_DATA_I[2:0] > `RLS_ROLE_MAX) ? ROUTE_ROLE_O : WR_DATA_I[2:0];
  wire [5:0] nh_wr = WR_DATA_I[13:8];
  wire nh_ok = (nh_wr >= `RLS_NHOP_MIN) && (nh_wr <= `RLS_NHOP_MAX);
  wire [5:0] nh_nxt = nh_ok ? nh_wr : NET_HOP_MAX_O;
  wire [5:0] bh_nxt = (WR_DATA_I[5:0] <= `RLS_BHOP_MAX) ? WR_DATA_I[5:0] : BCAST_HOP_LIMIT_O;
  wire [7:0] opt_wr = {WR_DATA_I[23:22], 2'h0, WR_DATA_I[19:16]};
  wire role_routes = (ROUTE_ROLE_O == 3'h0) || (ROUTE_ROLE_O == 3'h1) || (ROUTE_ROLE_O == 3'h4);
  wire role_poller = (ROUTE_ROLE_O == 3'h4) || (ROUTE_ROLE_O == 3'h6);
  wire rate_zero = (RF_DATA_RATE_I == 3'h0);
  wire [7:0] sel_flags = (API_MODE_I && FRAME_VALID_I) ? FRAME_TX_FLAGS_I : TX_OPTION_BITS_O;
  wire is_mesh = (sel_flags[`RLS_TXOPT_DM_HI:`RLS_TXOPT_DM_LO] == `RLS_DM_MESH);
  wire [5:0] bh_clamp = (BCAST_HOP_LIMIT_O > NET_HOP_MAX_O) ? NET_HOP_MAX_O : BCAST_HOP_LIMIT_O;
  reg [23:0] poll_cnt_r;

  // Counters; all volatile, zero from reset
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      RSSI_LAST_HOP_O <= `RLS_RSSI_RST;
      UNICAST_TRY_COUNT_O <= `RLS_CNT16_RST;
      GOOD_RX_FRAMES_O <= `RLS_CNT16_RST;
      TX_BYTE_COUNT_O <= `RLS_CNT32_RST;
      ACK_TIMEOUT_COUNT_O <= `RLS_CNT16_RST;
      CCA_BLOCKED_COUNT_O <= `RLS_CNT16_RST;
      SEND_FAIL_COUNT_O <= `RLS_CNT16_RST;
    end
    else
    begin
      if (RX_FRAME_I && !RX_IS_ACK_I)
        RSSI_LAST_HOP_O <= RX_RSSI_I;
      // Host write wins over increment
      if (WR_EN_I[0])
        UNICAST_TRY_COUNT_O <= WR_DATA_I[15:0];
      else if (UNICAST_SENT_I && retry_on && UNICAST_TRY_COUNT_O != `RLS_CNT16_MAX)
        UNICAST_TRY_COUNT_O <= UNICAST_TRY_COUNT_O + 16'h0001;
      if (WR_EN_I[1])
        GOOD_RX_FRAMES_O <= WR_DATA_I[15:0];
      else if (RX_FRAME_I && !RX_IS_ACK_I && GOOD_RX_FRAMES_O != `RLS_CNT16_MAX)
        GOOD_RX_FRAMES_O <= GOOD_RX_FRAMES_O + 16'h0001;
      // Byte count wraps; no saturation is specified for it
      if (WR_EN_I[2])
        TX_BYTE_COUNT_O <= WR_DATA_I;
      else
        TX_BYTE_COUNT_O <= byte_sum[31:0];
      if (WR_EN_I[3])
        ACK_TIMEOUT_COUNT_O <= WR_DATA_I[15:0];
      else if (ACK_TIMEOUT_I && ACK_TIMEOUT_COUNT_O != `RLS_CNT16_MAX)
        ACK_TIMEOUT_COUNT_O <= ACK_TIMEOUT_COUNT_O + 16'h0001;
      if (WR_EN_I[4])
        CCA_BLOCKED_COUNT_O <= WR_DATA_I[15:0];
      else if (cca_ev && CCA_BLOCKED_COUNT_O != `RLS_CNT16_MAX)
        CCA_BLOCKED_COUNT_O <= CCA_BLOCKED_COUNT_O + 16'h0001;
      if (WR_EN_I[5])
        SEND_FAIL_COUNT_O <= WR_DATA_I[15:0];
      else if (SEND_FAIL_I && SEND_FAIL_COUNT_O != `RLS_CNT16_MAX)
        SEND_FAIL_COUNT_O <= SEND_FAIL_COUNT_O + 16'h0001;
    end
  end

  // Configuration; out-of-range writes are dropped so old values stay valid
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ROUTE_ROLE_O <= `RLS_ROLE_RST;
      TX_OPTION_BITS_O <= `RLS_TXOPT_RST;
      BCAST_HOP_LIMIT_O <= `RLS_BHOP_RST;
      NET_HOP_MAX_O <= `RLS_NHOP_RST;
    end
    else
    begin
      if (WR_EN_I[6])
        ROUTE_ROLE_O <= role_nxt;
      if (WR_EN_I[7])
      begin
        BCAST_HOP_LIMIT_O <= bh_nxt;
        NET_HOP_MAX_O <= nh_nxt;
        TX_OPTION_BITS_O <= opt_wr;
      end
    end
  end

  // Derived per-transmission controls, registered
  always @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      EFF_TX_FLAGS_O <= 8'h00;
      EFF_BCAST_HOPS_O <= 6'h00;
      ROUTES_O <= 1'b0;
      REPEAT_BCAST_O <= 1'b0;
      HOLD_P2MP_O <= 1'b0;
      RELEASE_HELD_O <= 1'b0;
      POLL_PULSE_O <= 1'b0;
      poll_cnt_r <= 24'h000000;
    end
    else
    begin
      // Mesh bits forced off at rate zero trace and NACK only matter on mesh
      EFF_TX_FLAGS_O <= {(rate_zero ? 2'h0 : sel_flags[7:6]), 2'h0,
        sel_flags[`RLS_TXOPT_TRACE] & is_mesh & ~rate_zero,
        sel_flags[`RLS_TXOPT_NACK] & is_mesh & ~rate_zero,
        sel_flags[`RLS_TXOPT_NORD], sel_flags[`RLS_TXOPT_NOACK]};
      EFF_BCAST_HOPS_O <= (API_MODE_I && FRAME_VALID_I) ? FRAME_BCAST_RADIUS_I : bh_clamp;
      ROUTES_O <= role_routes;
      REPEAT_BCAST_O <= role_routes & ~rate_zero;
      HOLD_P2MP_O <= (ROUTE_ROLE_O == 3'h1);
      RELEASE_HELD_O <= (ROUTE_ROLE_O == 3'h1) & POLL_REQ_I;
      if (!role_poller || poll_cnt_r >= POLL_CYCLES - 24'h000001)
        poll_cnt_r <= 24'h000000;
      else
        poll_cnt_r <= poll_cnt_r + 24'h000001;
      POLL_PULSE_O <= role_poller && (poll_cnt_r >= POLL_CYCLES - 24'h000001);
    end
  end

endmodule // rls_top
